// ---- logic/ufc_channel_ctrl.sv ----
// Purpose: Per-channel FIFO, line format and modem control registers
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   Flow-control and interrupt engines sit outside this block
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`default_nettype none
module ufc_channel_ctrl
	import ufc_pkg::*;
#(
	parameter int FIFO_DEPTH = 64
) (
	// Bus clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [7:0]            haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// FIFO levels from the datapath
	input  wire logic [6:0]            rx_count,
	input  wire logic [6:0]            tx_count,
	// Controls to the datapath
	output ufc_fifo_cfg_t              fifo_cfg,
	output ufc_line_fmt_t              line_fmt,
	output ufc_modem_t                 modem,
	output logic                       rx_fifo_clear,
	output logic                       tx_fifo_clear,
	output logic                       rx_data_request,
	output logic                       tx_space_request,
	output logic                       tx_break_hold,
	output logic      [15:0]           baud_divisor
);
	// Seven-bit level inputs cannot count beyond 127
	if (FIFO_DEPTH < 64 || FIFO_DEPTH > 127) begin : g_bad_depth
		$error("FIFO_DEPTH must lie in 64..127");
	end

	logic [7:0] fifo_control;
	logic [7:0] line_format_control;
	logic [7:0] modem_line_control;
	logic [7:0] feature_control;
	logic [7:0] rx_trigger_value;
	logic [7:0] tx_trigger_value;
	logic [7:0] divisor_low_byte;
	logic [7:0] divisor_high_byte;
	logic       wr_pend;
	logic [7:0] wr_addr;
	logic       tx_filled_above;
	logic [6:0] rx_level;
	logic [6:0] tx_level;
	logic [7:0] next_rdata;
	logic       addr_ok;

	assign addr_ok = hsel && hready && htrans == UFC_HTRANS_NONSEQ && hsize == UFC_HSIZE_WORD;

	// Address phase captured; write data lands in next cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= UFC_RST_BYTE;
		end else begin
			wr_pend <= addr_ok && hwrite;
			wr_addr <= haddr;
		end
	end

	// FIFO control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fifo_control <= UFC_RST_BYTE;
		end else if (wr_pend && wr_addr == UFC_OFS_FIFO_CTRL) begin
			if (hwdata[0])
				fifo_control <= {hwdata[7:3], 2'b00, 1'b1};
			else
				fifo_control <= {fifo_control[7:1], 1'b0};
		end
	end

	// Clear pulses only act with FIFOs enabled in the same write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_fifo_clear <= 1'b0;
			tx_fifo_clear <= 1'b0;
		end else begin
			rx_fifo_clear <= wr_pend && wr_addr == UFC_OFS_FIFO_CTRL
				&& hwdata[0] && hwdata[1];
			tx_fifo_clear <= wr_pend && wr_addr == UFC_OFS_FIFO_CTRL
				&& hwdata[0] && hwdata[2];
		end
	end

	// Line format register and divisor latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			line_format_control <= UFC_RST_BYTE;
			divisor_low_byte    <= UFC_RST_BYTE;
			divisor_high_byte   <= UFC_RST_BYTE;
		end else if (wr_pend) begin
			if (wr_addr == UFC_OFS_LINE_FMT)
				line_format_control <= hwdata[7:0];
			if (wr_addr == UFC_OFS_DIVISOR_LO && line_format_control[7])
				divisor_low_byte <= hwdata[7:0];
			if (wr_addr == UFC_OFS_DIVISOR_HI && line_format_control[7])
				divisor_high_byte <= hwdata[7:0];
		end
	end

	// Modem control register, reserved bit kept zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			modem_line_control <= UFC_RST_BYTE;
		else if (wr_pend && wr_addr == UFC_OFS_MODEM_CTRL)
			modem_line_control <= hwdata[7:0] & UFC_MCR_MASK;
	end

	// Feature and programmable trigger registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			feature_control  <= UFC_RST_BYTE;
			rx_trigger_value <= UFC_RST_BYTE;
			tx_trigger_value <= UFC_RST_BYTE;
		end else if (wr_pend) begin
			if (wr_addr == UFC_OFS_FEATURE)
				feature_control <= hwdata[7:0];
			if (wr_addr == UFC_OFS_TRIG_VALUE && !feature_control[7])
				rx_trigger_value <= hwdata[7:0];
			if (wr_addr == UFC_OFS_TRIG_VALUE && feature_control[7])
				tx_trigger_value <= hwdata[7:0];
		end
	end

	// Trigger tables; one table choice for both directions
	always_comb begin
		rx_level = 7'd1;
		tx_level = 7'd1;
		case (feature_control[5:4])
			2'b00: begin
				case (fifo_control[7:6])
					2'b00: rx_level = 7'd1;
					2'b01: rx_level = 7'd4;
					2'b10: rx_level = 7'd8;
					default: rx_level = 7'd14;
				endcase
				tx_level = 7'd1;
			end
			2'b01: begin
				case (fifo_control[7:6])
					2'b00: rx_level = 7'd8;
					2'b01: rx_level = 7'd16;
					2'b10: rx_level = 7'd24;
					default: rx_level = 7'd28;
				endcase
				case (fifo_control[5:4])
					2'b00: tx_level = 7'd16;
					2'b01: tx_level = 7'd8;
					2'b10: tx_level = 7'd24;
					default: tx_level = 7'd30;
				endcase
			end
			2'b10: begin
				case (fifo_control[7:6])
					2'b00: rx_level = 7'd8;
					2'b01: rx_level = 7'd16;
					2'b10: rx_level = 7'd56;
					default: rx_level = 7'd60;
				endcase
				case (fifo_control[5:4])
					2'b00: tx_level = 7'd8;
					2'b01: tx_level = 7'd16;
					2'b10: tx_level = 7'd32;
					default: tx_level = 7'd56;
				endcase
			end
			default: begin
				rx_level = rx_trigger_value[6:0];
				tx_level = tx_trigger_value[6:0];
			end
		endcase
	end

	// Remember whether the last reload rose above the transmit trigger
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tx_filled_above <= 1'b0;
		else if (tx_count > tx_level)
			tx_filled_above <= 1'b1;
		else if (tx_count == 7'd0)
			tx_filled_above <= 1'b0;
	end

	// Level requests toward the interrupt logic
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_data_request  <= 1'b0;
			tx_space_request <= 1'b0;
		end else begin
			rx_data_request <= fifo_control[0] && rx_count >= rx_level;
			tx_space_request <= fifo_control[0] && (tx_filled_above
				? tx_count < tx_level : tx_count == 7'd0);
		end
	end

	// Decoded format toward the serial engines
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			line_fmt      <= '0;
			modem         <= '0;
			fifo_cfg      <= '0;
			tx_break_hold <= 1'b0;
			baud_divisor  <= 16'h0000;
		end else begin
			line_fmt.data_bits      <= 4'd5 + {2'b00, line_format_control[1:0]};
			// Counted in half bits so 1.5 stop bits stays exact
			line_fmt.stop_half_bits <= !line_format_control[2] ? 3'd2
				: (line_format_control[1:0] == 2'b00 ? 3'd3 : 3'd4);
			line_fmt.parity_on      <= line_format_control[3];
			line_fmt.parity_even    <= line_format_control[4];
			line_fmt.parity_forced  <= line_format_control[5];
			line_fmt.parity_value   <= !line_format_control[4];
			line_fmt.brk            <= line_format_control[6];
			line_fmt.divisor_sel    <= line_format_control[7];
			tx_break_hold           <= line_format_control[6];
			modem.dtr_n             <= !modem_line_control[0];
			modem.rts_n             <= !modem_line_control[1];
			modem.flow_use_dtr      <= modem_line_control[2];
			modem.loopback          <= modem_line_control[4];
			modem.xon_any           <= modem_line_control[5];
			fifo_cfg.enable         <= fifo_control[0];
			fifo_cfg.dma_mode       <= fifo_control[3];
			fifo_cfg.tx_sel         <= fifo_control[5:4];
			fifo_cfg.rx_sel         <= fifo_control[7:6];
			baud_divisor            <= {divisor_high_byte, divisor_low_byte};
		end
	end

	// Read mux; FIFO control is write-only and reads zero
	always_comb begin
		next_rdata = UFC_RST_BYTE;
		case (haddr)
			UFC_OFS_LINE_FMT:   next_rdata = line_format_control;
			UFC_OFS_MODEM_CTRL: next_rdata = modem_line_control;
			UFC_OFS_FEATURE:    next_rdata = feature_control;
			UFC_OFS_TRIG_VALUE: next_rdata = feature_control[7] ? tx_trigger_value
				: rx_trigger_value;
			UFC_OFS_STATUS:     next_rdata = {{2{fifo_control[0]}}, 4'h0,
				tx_space_request, rx_data_request};
			UFC_OFS_FIFO_LEVELS: next_rdata = {1'b0, rx_count};
			UFC_OFS_DIVISOR_LO: next_rdata = line_format_control[7] ? divisor_low_byte
				: UFC_RST_BYTE;
			UFC_OFS_DIVISOR_HI: next_rdata = line_format_control[7] ? divisor_high_byte
				: UFC_RST_BYTE;
			default:            next_rdata = UFC_RST_BYTE;
		endcase
	end

	// Zero wait state read data, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hrdata    <= (addr_ok && !hwrite) ? {24'h000000, next_rdata} : 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- logic/ufc_pkg.sv ----
// Purpose: Shared constants and types for the channel control block
// Assumes: AHB-Lite word-aligned register map
// Notes:   Offsets are byte addresses
package ufc_pkg;
	localparam logic [7:0] UFC_OFS_FIFO_CTRL   = 8'h00;
	localparam logic [7:0] UFC_OFS_LINE_FMT    = 8'h04;
	localparam logic [7:0] UFC_OFS_MODEM_CTRL  = 8'h08;
	localparam logic [7:0] UFC_OFS_FEATURE     = 8'h0C;
	localparam logic [7:0] UFC_OFS_TRIG_VALUE  = 8'h10;
	localparam logic [7:0] UFC_OFS_STATUS      = 8'h14;
	localparam logic [7:0] UFC_OFS_FIFO_LEVELS = 8'h18;
	localparam logic [7:0] UFC_OFS_DIVISOR_LO  = 8'h1C;
	localparam logic [7:0] UFC_OFS_DIVISOR_HI  = 8'h20;
	localparam logic [7:0] UFC_RST_BYTE        = 8'h00;
	localparam logic [7:0] UFC_MCR_MASK        = 8'hF7;
	localparam logic [1:0] UFC_HTRANS_NONSEQ   = 2'h2;
	localparam logic [2:0] UFC_HSIZE_WORD      = 3'h2;

	typedef struct packed {
		logic [1:0] rx_sel;
		logic [1:0] tx_sel;
		logic       dma_mode;
		logic       enable;
	} ufc_fifo_cfg_t;

	typedef struct packed {
		logic [3:0] data_bits;
		logic [2:0] stop_half_bits;
		logic       parity_on;
		logic       parity_even;
		logic       parity_forced;
		logic       parity_value;
		logic       brk;
		logic       divisor_sel;
	} ufc_line_fmt_t;

	typedef struct packed {
		logic dtr_n;
		logic rts_n;
		logic flow_use_dtr;
		logic loopback;
		logic xon_any;
	} ufc_modem_t;
endpackage

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the channel control block
// Assumes: Zero-wait slave, derived outputs settle two edges after a write
// Notes:   One idle cycle between transfers keeps checks simple
`default_nettype none
module tb
	import ufc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] FMTS [4] = '{8'h3B, 8'h45, 8'h8E, 8'h1C};
	localparam logic [7:0] TABS [3] = '{8'h00, 8'h10, 8'h20};
	localparam logic [6:0] TRIG [3] = '{7'd14, 7'd28, 7'd60};
	logic          hclk = 1'b0;
	logic          hresetn = 1'b0;
	logic          hsel = 1'b0;
	logic          hwrite = 1'b0;
	logic          load = 1'b0;
	logic          hready;
	logic [7:0]    haddr = 8'h00;
	logic [1:0]    htrans = 2'h0;
	logic [2:0]    hsize = UFC_HSIZE_WORD;
	logic [31:0]   hwdata = 32'h0;
	logic [31:0]   hrdata;
	logic [31:0]   rd_v;
	logic [6:0]    load_val = 7'h00;
	logic [6:0]    rx_count;
	logic [6:0]    tx_count;
	logic          hreadyout;
	logic          rx_fifo_clear;
	logic          tx_fifo_clear;
	logic          rx_data_request;
	logic          tx_break_hold;
	logic          tx_space_request;
	logic          hresp;
	logic [15:0]   baud_divisor;
	ufc_fifo_cfg_t fifo_cfg;
	ufc_line_fmt_t line_fmt;
	ufc_modem_t    modem;
	int            fail_count = 0;
	int            checked = 0;
	always #50 hclk = ~hclk;
	assign hready = hreadyout;
	ufc_channel_ctrl #(.FIFO_DEPTH(64)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rx_count, .tx_count, .fifo_cfg,
		.line_fmt, .modem, .rx_fifo_clear, .tx_fifo_clear, .rx_data_request,
		.tx_space_request, .tx_break_hold, .baud_divisor);
	ufc_fifo_model u_fifo (.hclk, .hresetn, .load, .load_val, .rx_fifo_clear, .tx_fifo_clear,
		.rx_count, .tx_count);
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				fail_count++;
				end_sim;
			end
			@(posedge hclk);
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= UFC_HTRANS_NONSEQ;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy;
		rd_v = hrdata;
	endtask
	task automatic settle;
		@(posedge hclk);
		@(negedge hclk);
	endtask
	task automatic lvl(input logic [6:0] v);
		@(posedge hclk);
		load <= 1'b1;
		load_val <= v;
		@(posedge hclk);
		load <= 1'b0;
		settle;
	endtask
	task automatic t_reset;
		xfer(1'b0, UFC_OFS_LINE_FMT, 8'h00);
		chk(rd_v[7:0], 8'h00);
		xfer(1'b0, UFC_OFS_MODEM_CTRL, 8'h00);
		chk(rd_v[7:0], 8'h00);
		chk({modem.dtr_n, modem.rts_n, fifo_cfg}, 8'hC0);
		$display("reset values done");
	endtask
	task automatic t_line;
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, UFC_OFS_LINE_FMT, FMTS[i]);
			settle;
			chk({line_fmt.data_bits, 3'h0, tx_break_hold},
				{4'h5 + {2'h0, FMTS[i][1:0]}, 3'h0, FMTS[i][6]});
			xfer(1'b0, UFC_OFS_LINE_FMT, 8'h00);
			chk(rd_v[7:0], FMTS[i]);
		end
		$display("line format done");
	endtask
	task automatic t_modem;
		xfer(1'b1, UFC_OFS_MODEM_CTRL, 8'h3F);
		settle;
		chk({3'h0, modem}, 8'h07);
		xfer(1'b0, UFC_OFS_MODEM_CTRL, 8'h00);
		chk(rd_v[7:0], 8'h37);
		$display("modem control done");
	endtask
	task automatic t_fifo;
		lvl(7'h05);
		xfer(1'b1, UFC_OFS_FIFO_CTRL, 8'hCB);
		settle;
		chk({1'b0, rx_count}, 8'h00);
		chk({1'b0, tx_count}, 8'h05);
		chk({2'h0, fifo_cfg}, 8'h33);
		xfer(1'b0, UFC_OFS_STATUS, 8'h00);
		chk({6'h0, rd_v[7:6]}, 8'h03);
		xfer(1'b1, UFC_OFS_FIFO_CTRL, 8'hF6);
		settle;
		chk({2'h0, fifo_cfg}, 8'h32);
		chk({1'b0, tx_count}, 8'h05);
		xfer(1'b1, UFC_OFS_FIFO_CTRL, 8'h05);
		settle;
		chk({1'b0, tx_count}, 8'h00);
		$display("fifo control done");
	endtask
	task automatic t_trig;
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, UFC_OFS_FEATURE, TABS[i]);
			xfer(1'b1, UFC_OFS_FIFO_CTRL, 8'hC1);
			lvl(TRIG[i] - 7'h01);
			chk({7'h0, rx_data_request}, 8'h00);
			lvl(TRIG[i]);
			chk({7'h0, rx_data_request}, 8'h01);
			lvl(TRIG[i] - 7'h01);
			chk({7'h0, rx_data_request}, 8'h00);
		end
		$display("trigger tables done");
	endtask
	task automatic t_div;
		xfer(1'b1, UFC_OFS_LINE_FMT, 8'h80);
		xfer(1'b1, UFC_OFS_DIVISOR_LO, 8'h34);
		xfer(1'b1, UFC_OFS_DIVISOR_HI, 8'h12);
		settle;
		chk(baud_divisor[7:0], 8'h34);
		chk(baud_divisor[15:8], 8'h12);
		xfer(1'b0, UFC_OFS_DIVISOR_LO, 8'h00);
		chk(rd_v[7:0], 8'h34);
		chk({7'h0, hresp}, 8'h00);
		xfer(1'b1, UFC_OFS_LINE_FMT, 8'h3C);
		xfer(1'b1, UFC_OFS_DIVISOR_LO, 8'h55);
		settle;
		chk(baud_divisor[7:0], 8'h34);
		chk({line_fmt.stop_half_bits, line_fmt.parity_on, line_fmt.parity_even,
			line_fmt.parity_forced, line_fmt.parity_value, 1'b0}, 8'h7C);
		xfer(1'b1, UFC_OFS_LINE_FMT, 8'h2F);
		settle;
		chk({line_fmt.stop_half_bits, line_fmt.parity_on, line_fmt.parity_even,
			line_fmt.parity_forced, line_fmt.parity_value, 1'b0}, 8'h96);
		$display("divisor and format done");
	endtask
	task automatic t_prog;
		xfer(1'b1, UFC_OFS_FEATURE, 8'h30);
		xfer(1'b1, UFC_OFS_TRIG_VALUE, 8'h05);
		xfer(1'b1, UFC_OFS_FEATURE, 8'hB0);
		xfer(1'b1, UFC_OFS_TRIG_VALUE, 8'h03);
		xfer(1'b0, UFC_OFS_TRIG_VALUE, 8'h00);
		chk(rd_v[7:0], 8'h03);
		lvl(7'h05);
		chk({6'h0, tx_space_request, rx_data_request}, 8'h01);
		lvl(7'h02);
		chk({6'h0, tx_space_request, rx_data_request}, 8'h02);
		lvl(7'h00);
		chk({6'h0, tx_space_request, rx_data_request}, 8'h02);
		lvl(7'h02);
		chk({6'h0, tx_space_request, rx_data_request}, 8'h00);
		$display("programmable triggers done");
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_line;
		t_modem;
		t_fifo;
		t_trig;
		t_div;
		t_prog;
		end_sim;
	end
endmodule
`default_nettype wire

// ---- testbench/ufc_chk.sv ----
// Purpose: Bus-side checks for the channel control block
// Assumes: Zero-wait slave, writes land at the end of the data phase
// Notes:   Derived outputs are judged two edges after the data phase, clear pulses one or two edges after
`default_nettype none
module ufc_chk
	import ufc_pkg::*;
(
	// Bus
	input wire logic          hclk,
	input wire logic          hresetn,
	input wire logic          hsel,
	input wire logic [7:0]    haddr,
	input wire logic [1:0]    htrans,
	input wire logic          hwrite,
	input wire logic [31:0]   hwdata,
	input wire logic          hready,
	// Controls
	input wire ufc_fifo_cfg_t fifo_cfg,
	input wire ufc_line_fmt_t line_fmt,
	input wire ufc_modem_t    modem,
	input wire logic          rx_fifo_clear,
	input wire logic          tx_fifo_clear,
	input wire logic          tx_break_hold
);
	logic       wr_q;
	logic [7:0] a_q;
	logic [7:0] d1;
	logic [7:0] d2;
	logic       lf;
	logic       mw;
	logic       fw;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			a_q <= 8'h00;
			d1 <= 8'h00;
			d2 <= 8'h00;
		end else begin
			wr_q <= hready && hsel && hwrite && htrans == UFC_HTRANS_NONSEQ;
			a_q <= haddr;
			d1 <= hwdata[7:0];
			d2 <= d1;
		end
	end
	assign lf = wr_q && a_q == UFC_OFS_LINE_FMT;
	assign mw = wr_q && a_q == UFC_OFS_MODEM_CTRL;
	assign fw = wr_q && a_q == UFC_OFS_FIFO_CTRL;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	data_len_a: assert property (lf |-> ##2 line_fmt.data_bits == 4'h5 + {2'h0, d2[1:0]})
		else $error("word length wrong");
	stop_bits_a: assert property (lf |-> ##2 line_fmt.stop_half_bits ==
		(!d2[2] ? 3'h2 : (d2[1:0] == 2'h0 ? 3'h3 : 3'h4))) else $error("stop length wrong");
	parity_sel_a: assert property (lf |-> ##2 {line_fmt.parity_forced,
		line_fmt.parity_even, line_fmt.parity_on} == d2[5:3]) else $error("parity wrong");
	break_hold_a: assert property (lf |-> ##2 tx_break_hold == $past(hwdata[6], 2))
		else $error("break wrong");
	modem_pins_a: assert property (mw |-> ##2 modem == {~d2[0], ~d2[1], d2[2], d2[4], d2[5]})
		else $error("modem wrong");
	fifo_en_a: assert property (fw |-> ##2 fifo_cfg.enable == d2[0])
		else $error("fifo enable wrong");
	fifo_field_a: assert property (fw && hwdata[0] |-> ##2 fifo_cfg[5:1] == d2[7:3])
		else $error("fifo fields wrong");
	fifo_keep_a: assert property (fw && !hwdata[0] |-> ##2 fifo_cfg[5:1] == $past(fifo_cfg[5:1], 2))
		else $error("fifo fields changed");
	rx_clear_a: assert property (fw && hwdata[1] && hwdata[0] |-> ##[1:2] rx_fifo_clear)
		else $error("no rx clear");
	tx_clear_a: assert property (fw && hwdata[2] && hwdata[0] |-> ##[1:2] tx_fifo_clear)
		else $error("no tx clear");
endmodule
bind ufc_channel_ctrl ufc_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .fifo_cfg, .line_fmt, .modem, .rx_fifo_clear, .tx_fifo_clear, .tx_break_hold);
`default_nettype wire

// ---- testbench/ufc_fifo_model.sv ----
// Purpose: Datapath stand-in holding the two FIFO levels
// Assumes: Levels loaded by the bench, cleared by the block's pulses
// Notes:   No serial traffic; only the counts matter here
`default_nettype none
module ufc_fifo_model (
	// Clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// Level load and clears
	input wire logic       load,
	input wire logic [6:0] load_val,
	input wire logic       rx_fifo_clear,
	input wire logic       tx_fifo_clear,
	// Levels to the block
	output logic     [6:0] rx_count,
	output logic     [6:0] tx_count
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_count <= 7'h00;
			tx_count <= 7'h00;
		end else begin
			if (load) begin
				rx_count <= load_val;
				tx_count <= load_val;
			end
			// Pointers only, shift registers keep their bits
			if (rx_fifo_clear)
				rx_count <= 7'h00;
			if (tx_fifo_clear)
				tx_count <= 7'h00;
		end
	end
endmodule
`default_nettype wire
